//--- pkg/wdrc_pkg.sv
// Package: register map, fields, reset values and timing constants
package wdrc_pkg;
  // Word byte addresses on the bus
  localparam logic [4:0] ADDR_CAUSE = 5'h00;
  localparam logic [4:0] ADDR_SOFTWARE_RESET_REQUEST = 5'h04;
  localparam logic [4:0] ADDR_WCTRL = 5'h08;
  localparam logic [4:0] ADDR_WWIN = 5'h0c;
  localparam logic [4:0] ADDR_WSTAT = 5'h10;
  // Reset-cause bit positions
  localparam int POS_POR = 0;
  localparam int POS_EXT = 1;
  localparam int POS_BOR = 2;
  localparam int POS_WDG = 3;
  localparam int POS_DBG = 4;
  localparam int POS_SW = 5;
  // Control field positions
  localparam int POS_CE = 0;
  localparam int POS_EN = 1;
  localparam int POS_PER_LO = 2;
  localparam logic [7:0] SOFTWARE_RESET_REQUEST_RESET = 8'h00;
  localparam logic [3:0] PER_MAX_CODE = 4'ha;
  localparam int SYNC_STAGES = 2;
  // Reset pulse: 1 to 2 cycles of the 2 MHz oscillator (500 ns each)
  localparam int RST_PULSE_NS = 500;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    WDRC_OFF = 2'b00,
    WDRC_CLOSED = 2'b01,
    WDRC_OPEN = 2'b10
  } wdrc_phase_t;
endpackage : wdrc_pkg

//--- rtl/wdrc_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module wdrc_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  // First flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : wdrc_sync
`default_nettype wire

//--- rtl/wdrc_toggle_sync.sv
// Event crossing: toggle in, three flops, edge out
`timescale 1ns/1ps
`default_nettype none
module wdrc_toggle_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tgl_i,
  output logic pulse_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Edge detect reads only the second and third flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      pulse_o <= 1'b0;
    end else begin
      s1_r <= tgl_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pulse_o <= s2_r ^ s3_r;
    end
  end
endmodule : wdrc_toggle_sync
`default_nettype wire

//--- rtl/wdrc_top.sv
// Watchdog with window mode, reset-cause flags and software reset
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Reset events set cause flags; write one clears
// - Power-on flag set on POR; W1C only
// - Software reset bit resets system, self-clears, protected
// - Debug-port reset only from external programmer
// - Enabled watchdog resets system on missed clear
// - Normal mode clear restarts period; eleven periods
// - Clear in closed window resets immediately
// - Open period follows closed; total is sum
// - Watchdog runs in sleep, independent clock
// - Counter advances on 1 kHz tick
// - Update needs protected write plus change-enable
// - Lock fuse blocks control register writes
// - Watchdog resumes configured after system reset
// - Locked: closed period fixed, window enable writable
// - Default periods come from fuses
// - Control layout period 5:2, enable 1, change 0
// - Codes 0-10 give 8..8K ticks; others none
// - Window register mirrors layout with closed period
// - Busy flag while writes cross to tick domain
// - Reset pulse lasts one to two 2 MHz cycles
module wdrc_top #(
  parameter int CNT_W = 14
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic por_event_i,
  input wire logic ext_reset_event_i,
  input wire logic brownout_event_i,
  input wire logic debug_port_reset_event_i,
  input wire logic protect_open_i,
  input wire logic lock_fuse_i,
  input wire logic [3:0] fuse_period_i,
  input wire logic fuse_enable_i,
  input wire logic [3:0] fuse_closed_period_i,
  input wire logic fuse_window_enable_i,
  input wire logic tick_i,
  input wire logic watchdog_clear_instruction_i,
  output logic system_reset_o,
  output logic watchdog_reset_o,
  output logic soft_reset_o
);
  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic [5:0] cause_r;
  logic software_reset_request_r;
  logic [3:0] timeout_period_select_r;
  logic enable_r;
  logic [3:0] closed_window_period_select_r;
  logic window_enable_r;
  logic sync_in_progress_flag_r;
  logic fuse_loaded_r;
  logic req;
  logic wr;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic cfg_tgl_r;
  logic cfg_ack;
  logic clr_tgl_r;
  logic tick_s;
  logic tick_d_r;
  logic tick_rise;
  logic clr_pulse;
  logic [1:0] ack_tgl_r;
  logic ack_seen;
  logic wd_fire_r;
  logic [7:0] rst_cnt_r;
  logic [7:0] rst_cnt_nxt;
  logic [CNT_W-1:0] cnt_r;
  wdrc_pkg::wdrc_phase_t phase_r;
  logic [3:0] sh_per_r;
  logic [3:0] sh_closed_window_period_select_r;
  logic sh_en_r;
  logic sh_wen_r;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign wr_lane0 = wr && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // Timeout ticks for a period code, zero means no timeout
  function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] code);
    if (code <= wdrc_pkg::PER_MAX_CODE) begin
      period_ticks = CNT_W'(14'h0008 << code);
    end else begin
      period_ticks = '0;
    end
  endfunction : period_ticks

  // Read mux over byte-wide registers
  always_comb begin
    case (wb_adr_i)
      wdrc_pkg::ADDR_CAUSE: rbyte = {2'b00, cause_r};
      wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST: rbyte = {7'h00, software_reset_request_r};
      wdrc_pkg::ADDR_WCTRL: rbyte = {2'b00, timeout_period_select_r,
                                     enable_r, 1'b0};
      wdrc_pkg::ADDR_WWIN: rbyte = {2'b00, closed_window_period_select_r,
                                    window_enable_r, 1'b0};
      wdrc_pkg::ADDR_WSTAT: rbyte = {7'h00, sync_in_progress_flag_r};
      default: rbyte = 8'h00;
    endcase
  end

  // One-cycle ack, data registered with it; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Reset-cause flags
  // ------------------------------------------------------------
  // Sets win over write-one clears; debug flag only from its pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (wr_lane0 && wb_adr_i == wdrc_pkg::ADDR_CAUSE && wbyte[i]) begin
          cause_r[i] <= 1'b0;
        end
      end
      if (por_event_i) begin
        cause_r <= 6'h01;
      end else begin
        if (ext_reset_event_i) cause_r[wdrc_pkg::POS_EXT] <= 1'b1;
        if (brownout_event_i) cause_r[wdrc_pkg::POS_BOR] <= 1'b1;
        if (debug_port_reset_event_i) begin
          cause_r[wdrc_pkg::POS_DBG] <= 1'b1;
        end
        if (wd_fire_r) cause_r[wdrc_pkg::POS_WDG] <= 1'b1;
        if (software_reset_request_r) begin
          cause_r[wdrc_pkg::POS_SW] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Software reset request
  // ------------------------------------------------------------
  // Protected write sets it; cleared as the reset issues
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      software_reset_request_r <= wdrc_pkg::SOFTWARE_RESET_REQUEST_RESET[0];
    end else if (software_reset_request_r) begin
      software_reset_request_r <= 1'b0;
    end else if (wr_lane0 && wb_adr_i == wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST &&
                 protect_open_i) begin
      software_reset_request_r <= wbyte[0];
    end
  end

  // ------------------------------------------------------------
  // Control registers, bus side
  // ------------------------------------------------------------
  // Fuse values load after release and again on each POR; configured state survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_loaded_r <= 1'b0;
      timeout_period_select_r <= 4'h0;
      enable_r <= 1'b0;
      closed_window_period_select_r <= 4'h0;
      window_enable_r <= 1'b0;
      cfg_tgl_r <= 1'b0;
    end else if (!fuse_loaded_r || por_event_i) begin
      fuse_loaded_r <= 1'b1;
      timeout_period_select_r <= fuse_period_i;
      enable_r <= fuse_enable_i;
      closed_window_period_select_r <= fuse_closed_period_i;
      window_enable_r <= fuse_window_enable_i;
      cfg_tgl_r <= ~cfg_tgl_r;
    end else if (wr_lane0 && protect_open_i) begin
      if (wb_adr_i == wdrc_pkg::ADDR_WCTRL && wbyte[wdrc_pkg::POS_CE] &&
          !lock_fuse_i) begin
        timeout_period_select_r <= wbyte[5:2];
        enable_r <= wbyte[wdrc_pkg::POS_EN];
        cfg_tgl_r <= ~cfg_tgl_r;
      end else if (wb_adr_i == wdrc_pkg::ADDR_WWIN &&
                   wbyte[wdrc_pkg::POS_CE]) begin
        if (!lock_fuse_i) begin
          closed_window_period_select_r <= wbyte[5:2];
        end
        window_enable_r <= wbyte[wdrc_pkg::POS_EN];
        cfg_tgl_r <= ~cfg_tgl_r;
      end
    end
  end

  // Busy while a change is crossing, only with watchdog enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_in_progress_flag_r <= 1'b0;
      ack_tgl_r <= 2'b00;
    end else begin
      ack_tgl_r <= {ack_tgl_r[0], cfg_ack};
      if (wr_lane0 && protect_open_i && enable_r &&
          (wb_adr_i == wdrc_pkg::ADDR_WCTRL ||
           wb_adr_i == wdrc_pkg::ADDR_WWIN)) begin
        sync_in_progress_flag_r <= 1'b1;
      end else if (ack_seen || !enable_r) begin
        sync_in_progress_flag_r <= 1'b0;
      end
    end
  end
  assign ack_seen = ack_tgl_r[1] == cfg_tgl_r;

  // Clear instruction as a toggle toward the tick domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_tgl_r <= 1'b0;
    end else if (watchdog_clear_instruction_i) begin
      clr_tgl_r <= ~clr_tgl_r;
    end
  end

  // ------------------------------------------------------------
  // Tick domain: 1 kHz tick sampled, counter and windows
  // ------------------------------------------------------------
  wdrc_sync u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(tick_i),
    .q_o(tick_s)
  );

  wdrc_toggle_sync u_clr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tgl_i(clr_tgl_r),
    .pulse_o(clr_pulse)
  );

  assign tick_rise = tick_s && !tick_d_r;

  // Shadow copies taken once the change has crossed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_d_r <= 1'b0;
      sh_per_r <= 4'h0;
      sh_closed_window_period_select_r <= 4'h0;
      sh_en_r <= 1'b0;
      sh_wen_r <= 1'b0;
      cfg_ack <= 1'b0;
    end else begin
      tick_d_r <= tick_s;
      if (cfg_ack != cfg_tgl_r) begin
        sh_per_r <= timeout_period_select_r;
        sh_closed_window_period_select_r <= closed_window_period_select_r;
        sh_en_r <= enable_r;
        sh_wen_r <= window_enable_r;
        cfg_ack <= cfg_tgl_r;
      end
    end
  end

  // Counts ticks per phase; clears and expiry decide the outcome
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= wdrc_pkg::WDRC_OFF;
      cnt_r <= '0;
      wd_fire_r <= 1'b0;
    end else begin
      wd_fire_r <= 1'b0;
      case (phase_r)
        wdrc_pkg::WDRC_OFF: begin
          cnt_r <= '0;
          if (sh_en_r) begin
            phase_r <= sh_wen_r ? wdrc_pkg::WDRC_CLOSED : wdrc_pkg::WDRC_OPEN;
          end
        end
        wdrc_pkg::WDRC_CLOSED: begin
          if (!sh_en_r) begin
            phase_r <= wdrc_pkg::WDRC_OFF;
          end else if (clr_pulse) begin
            wd_fire_r <= 1'b1;
            phase_r <= wdrc_pkg::WDRC_OFF;
          end else if (tick_rise) begin
            if (period_ticks(sh_closed_window_period_select_r) != '0 &&
                cnt_r + 1'b1 >= period_ticks(sh_closed_window_period_select_r)) begin
              cnt_r <= '0;
              phase_r <= wdrc_pkg::WDRC_OPEN;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        wdrc_pkg::WDRC_OPEN: begin
          if (!sh_en_r) begin
            phase_r <= wdrc_pkg::WDRC_OFF;
          end else if (clr_pulse) begin
            cnt_r <= '0;
            phase_r <= sh_wen_r ? wdrc_pkg::WDRC_CLOSED : wdrc_pkg::WDRC_OPEN;
          end else if (tick_rise) begin
            if (period_ticks(sh_per_r) != '0 &&
                cnt_r + 1'b1 >= period_ticks(sh_per_r)) begin
              wd_fire_r <= 1'b1;
              phase_r <= wdrc_pkg::WDRC_OFF;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        default: phase_r <= wdrc_pkg::WDRC_OFF;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Reset outputs
  // ------------------------------------------------------------
  // Stretch the watchdog reset over one 2 MHz cycle
  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    if (wd_fire_r) begin
      rst_cnt_nxt = 8'(wdrc_pkg::RST_PULSE_CYC);
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_nxt = rst_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt_r <= 8'h00;
      watchdog_reset_o <= 1'b0;
      soft_reset_o <= 1'b0;
      system_reset_o <= 1'b0;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      watchdog_reset_o <= rst_cnt_nxt != 8'h00;
      soft_reset_o <= software_reset_request_r;
      system_reset_o <= (rst_cnt_nxt != 8'h00) || software_reset_request_r;
    end
  end
endmodule : wdrc_top
`default_nettype wire

//--- tb/wdrc_assertions.sv
// Checker on the watchdog top ports
`timescale 1ns/1ps
`default_nettype none
module wdrc_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic protect_open_i,
  input wire logic system_reset_o,
  input wire logic watchdog_reset_o,
  input wire logic soft_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] hi_r;
  logic req;
  logic swr;
  // Bus request and soft reset write decode
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign swr = req && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
    && wb_adr_i == wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST;
  // Cycles the watchdog reset has stood
  always_ff @(posedge clk_i) begin
    if (rst_i || !watchdog_reset_o) hi_r <= 8'h00;
    else hi_r <= hi_r + 8'h01;
  end
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("bus request not acked next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ctrl_layout: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i == wdrc_pkg::ADDR_WCTRL |-> wb_dat_o[31:6] == '0
    && !wb_dat_o[0]) else $error("control read shows reserved bits");
  a_sw_fires: assert property (swr && protect_open_i
    |-> ##[1:3] soft_reset_o) else $error("soft reset not issued");
  a_sw_guard: assert property (swr && !protect_open_i
    && !soft_reset_o |=> !soft_reset_o [*3])
    else $error("unprotected soft reset acted");
  a_sw_pulse: assert property (soft_reset_o
    |-> system_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  a_wd_system: assert property (watchdog_reset_o
    |-> system_reset_o) else $error("watchdog reset not system reset");
  a_wd_width: assert property ($fell(watchdog_reset_o)
    |-> int'(hi_r) == wdrc_pkg::RST_PULSE_CYC)
    else $error("watchdog reset width wrong");
  a_wd_cap: assert property (int'(hi_r) <= wdrc_pkg::RST_PULSE_CYC)
    else $error("watchdog reset too long");
  a_quiet_start: assert property ($fell(rst_i)
    |-> !system_reset_o && !wb_ack_o) else $error("outputs after reset");
  cover property (swr && protect_open_i);
  cover property ($rose(watchdog_reset_o));
  cover property (wb_ack_o && wb_we_i);
endmodule : wdrc_checker
bind wdrc_top wdrc_checker u_chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
  .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .protect_open_i, .system_reset_o, .watchdog_reset_o, .soft_reset_o);
`default_nettype wire

//--- tb/wdrc_core_model.sv
// Core-side model: protection window and clear pulses
`timescale 1ns/1ps
`default_nettype none
module wdrc_core_model #(
  parameter int PROT_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic unlock_i,
  input wire logic clear_req_i,
  output logic protect_open_o,
  output logic clear_o
);
  logic [7:0] win_r;
  // Timed window opened by the unlock key
  always_ff @(posedge clk_i) begin
    if (rst_i) win_r <= 8'h00;
    else if (unlock_i) win_r <= 8'(PROT_CYC);
    else if (win_r != 8'h00) win_r <= win_r - 8'h01;
  end
  assign protect_open_o = (win_r != 8'h00);
  // One-cycle clear instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) clear_o <= 1'b0;
    else clear_o <= clear_req_i;
  end
endmodule : wdrc_core_model
`default_nettype wire

//--- tb/wdrc_top_tb.sv
// Testbench for the watchdog and reset-cause block
`timescale 1ns/1ps
`default_nettype none
module wdrc_top_tb;
  typedef struct packed {
    logic we;
    logic prot;
    logic [4:0] adr;
    logic [7:0] dat;
    logic [7:0] exp;
    logic [7:0] msk;
  } wdrc_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [3:0] evt = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, lock = 1'b0, tick = 1'b0;
  logic clr_req = 1'b0, unlock = 1'b0;
  int fired = 0;
  int base = 0;
  logic prot_open, wd_clr, ack, sys_rst, wd_rst, sw_rst;
  logic [31:0] rdat;
  logic [7:0] q;
  logic [5:0] tdiv = 6'h00;
  int failures = 0;
  int check_count = 0;
  int n;
  // Reserved bits written as zero, except the 8'hff write to unmapped 5'h14
  wdrc_row_t rows [14] = '{
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WCTRL, 8'h00, 8'h08, 8'hff},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WWIN, 8'h00, 8'h04, 8'hfe},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST, 8'h00, 8'h00, 8'hff},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WSTAT, 8'h00, 8'h00, 8'hff},
    '{1'b1, 1'b0, 5'h14, 8'hff, 8'h00, 8'h00},
    '{1'b0, 1'b0, 5'h14, 8'h00, 8'h00, 8'hff},
    '{1'b1, 1'b0, wdrc_pkg::ADDR_WCTRL, 8'h0b, 8'h00, 8'h00},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WCTRL, 8'h00, 8'h08, 8'hff},
    '{1'b1, 1'b1, wdrc_pkg::ADDR_WCTRL, 8'h12, 8'h00, 8'h00},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WCTRL, 8'h00, 8'h08, 8'hff},
    '{1'b1, 1'b1, wdrc_pkg::ADDR_WCTRL, 8'h11, 8'h00, 8'h00},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WCTRL, 8'h00, 8'h10, 8'hff},
    '{1'b1, 1'b1, wdrc_pkg::ADDR_WWIN, 8'h09, 8'h00, 8'h00},
    '{1'b0, 1'b0, wdrc_pkg::ADDR_WWIN, 8'h00, 8'h08, 8'hfe}};
  // Clock and slow oscillator tick
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tdiv <= (tdiv == 6'h13) ? 6'h00 : tdiv + 6'h01;
    if (tdiv == 6'h13) tick <= ~tick;
    if (wd_rst === 1'b1) fired <= fired + 1; // Cycles of watchdog reset
  end
  wdrc_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .unlock_i(unlock),
    .clear_req_i(clr_req), .protect_open_o(prot_open), .clear_o(wd_clr));
  wdrc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .por_event_i(evt[0]),
    .ext_reset_event_i(evt[1]), .brownout_event_i(evt[2]),
    .debug_port_reset_event_i(evt[3]), .protect_open_i(prot_open),
    .lock_fuse_i(lock), .fuse_period_i(4'h2), .fuse_enable_i(1'b0),
    .fuse_closed_period_i(4'h1), .fuse_window_enable_i(1'b0),
    .tick_i(tick), .watchdog_clear_instruction_i(wd_clr),
    .system_reset_o(sys_rst), .watchdog_reset_o(wd_rst),
    .soft_reset_o(sw_rst));
  task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  // One classic Wishbone cycle, read byte left in q
  task automatic bus(input logic w, input logic [4:0] a, logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 40) chk(8'h00, 8'h01, "no bus ack");
  endtask : bus
  task automatic pwr(input logic [4:0] a, input logic [7:0] d);
    unlock <= 1'b1;
    @(posedge clk_i);
    unlock <= 1'b0;
    bus(1'b1, a, d);
  endtask : pwr
  task automatic clear();
    clr_req <= 1'b1;
    @(posedge clk_i);
    clr_req <= 1'b0;
  endtask : clear
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    @(posedge clk_i);
    evt[i] <= 1'b0;
    @(posedge clk_i);
  endtask : pulse
  task automatic wait_fire(input int lim);
    n = 0;
    while (wd_rst !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_fire
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    foreach (rows[i]) begin
      if (rows[i].prot) pwr(rows[i].adr, rows[i].dat);
      else bus(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk(q & rows[i].msk, rows[i].exp, "reg row");
    end
    pulse(0);
    bus(1'b0, wdrc_pkg::ADDR_CAUSE, 8'h00);
    chk(q, 8'h01, "power-on flag");
    pulse(1);
    pulse(2);
    pulse(3);
    bus(1'b0, wdrc_pkg::ADDR_CAUSE, 8'h00);
    chk(q, 8'h17, "event flags");
    bus(1'b1, wdrc_pkg::ADDR_CAUSE, 8'h02);
    bus(1'b0, wdrc_pkg::ADDR_CAUSE, 8'h00);
    chk(q, 8'h15, "write one clear");
    bus(1'b1, wdrc_pkg::ADDR_CAUSE, 8'h3d);
    bus(1'b0, wdrc_pkg::ADDR_CAUSE, 8'h00);
    chk(q, 8'h00, "all flags cleared");
    bus(1'b1, wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST, 8'h01);
    pwr(wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST, 8'h01);
    @(posedge clk_i);
    chk({6'h0, sw_rst, sys_rst}, 8'h03, "soft reset pulse");
    @(posedge clk_i);
    chk({6'h0, sw_rst, sys_rst}, 8'h00, "soft reset one cycle");
    repeat (2) @(posedge clk_i);
    bus(1'b0, wdrc_pkg::ADDR_CAUSE, 8'h00);
    chk(q, 8'h20, "soft reset flag");
    bus(1'b0, wdrc_pkg::ADDR_SOFTWARE_RESET_REQUEST, 8'h00);
    chk(q, 8'h00, "soft reset self clear");
    bus(1'b1, wdrc_pkg::ADDR_CAUSE, 8'h20);
    // Normal mode: clears keep it quiet, then a timeout
    pwr(wdrc_pkg::ADDR_WCTRL, 8'h03);
    base = fired;
    repeat (6) begin
      repeat (160) @(posedge clk_i);
      clear();
    end
    chk({7'h0, fired != base}, 8'h00, "fired despite clears");
    wait_fire(500);
    chk({7'h0, n > 285 && n < 330}, 8'h01, "normal timeout");
    chk({6'h0, wd_rst, sys_rst}, 8'h03, "watchdog system reset");
    bus(1'b0, wdrc_pkg::ADDR_CAUSE, 8'h00);
    chk(q & 8'h08, 8'h08, "watchdog flag");
    // Window mode: early clear fires, open clear holds
    repeat (100) @(posedge clk_i);
    pwr(wdrc_pkg::ADDR_WWIN, 8'h03);
    bus(1'b0, wdrc_pkg::ADDR_WSTAT, 8'h00);
    chk(q, 8'h01, "busy while crossing");
    repeat (10) @(posedge clk_i);
    bus(1'b0, wdrc_pkg::ADDR_WSTAT, 8'h00);
    chk(q, 8'h00, "busy cleared");
    // First clear leaves open phase, second lands in closed
    clear();
    repeat (10) @(posedge clk_i);
    clear();
    wait_fire(60);
    chk({7'h0, n < 60}, 8'h01, "closed window clear");
    repeat (550) @(posedge clk_i);
    base = fired;
    clear();
    repeat (240) @(posedge clk_i);
    chk({7'h0, fired != base}, 8'h00, "open window clear");
    wait_fire(700);
    chk({7'h0, n > 330 && n < 480}, 8'h01, "closed plus open");
    // Reserved open period: no timeout once closed ends
    repeat (120) @(posedge clk_i);
    pwr(wdrc_pkg::ADDR_WCTRL, 8'h2f);
    wait_fire(700);
    chk({7'h0, n == 700}, 8'h01, "reserved code no timeout");
    // Lock fuse
    lock <= 1'b1;
    pwr(wdrc_pkg::ADDR_WCTRL, 8'h01);
    bus(1'b0, wdrc_pkg::ADDR_WCTRL, 8'h00);
    chk(q, 8'h2e, "locked control");
    pwr(wdrc_pkg::ADDR_WWIN, 8'h15);
    bus(1'b0, wdrc_pkg::ADDR_WWIN, 8'h00);
    chk(q & 8'hfe, 8'h00, "locked window");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus(1'b0, wdrc_pkg::ADDR_WCTRL, 8'h00);
    chk(q, 8'h08, "fuse defaults again");
    summarize();
  end
endmodule : wdrc_top_tb
`default_nettype wire
